/* logic/pmrs_pkg.sv */
/*
 Constants for the power, clock and reset sequencer: register offsets,
 field positions, reset values, state codes and timing counts.
 Assumes a 10 MHz always-on sequencer clock.
*/
package pmrs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
    localparam logic [7:0] OFS_PLL_CFG = 8'h04;
    localparam logic [7:0] OFS_CLK_SRC = 8'h08;
    localparam logic [7:0] OFS_CPU_DIV = 8'h0C;
    localparam logic [7:0] OFS_USB_DIV = 8'h10;
    localparam logic [7:0] OFS_PWR_MODE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PCLK_EN = 8'h1C;
    localparam logic [7:0] OFS_MEM_MAP = 8'h20;
    localparam logic [7:0] OFS_BOD_STAT = 8'h24;
    // field positions
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_CONN_BIT = 1;
    localparam int PLL_N_LSB = 0;
    localparam int PLL_M_LSB = 8;
    // reset values and the debug lock signature
    localparam logic [7:0] PLL_N_RST = 8'h00;
    localparam logic [14:0] PLL_M_RST = 15'h0000;
    localparam logic [31:0] PCLK_EN_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] DEBUG_SIG = 32'h8765_4321;
    // clock sources and vector maps
    localparam logic [1:0] SRC_RC = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_RTC = 2'h2;
    localparam logic [1:0] MAP_BOOT = 2'h0;
    localparam logic [1:0] MAP_SRAM = 2'h1;
    localparam logic [1:0] MAP_EXT = 2'h2;
    // power mode commands
    localparam logic [1:0] CMD_IDLE = 2'h1;
    localparam logic [1:0] CMD_SLEEP = 2'h2;
    localparam logic [1:0] CMD_PDOWN = 2'h3;
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN = 3'b001,
        ST_IDLE = 3'b010,
        ST_SLEEP = 3'b011,
        ST_PDOWN = 3'b100,
        ST_WAKE_OSC = 3'b101,
        ST_WAKE_RES = 3'b110
    } pmrs_state_e;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RC_START_NS = 60000;
    localparam int FLASH_START_NS = 100000;
    localparam logic [11:0] RC_START_CYC = 12'((RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] FLASH_CYC = 12'((FLASH_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] RC_WAKE_CYC = 12'h004;
    localparam logic [12:0] XTAL_WAKE_CYC = 13'h1000;
    localparam logic [7:0] RST_CLKS = 8'h10;
endpackage

/* logic/pmrs_sequencer.sv */
/*
 Power mode, clock and reset sequencer: reset combining and release,
 idle/sleep/power-down control with wake timing, synthesizer control
 register, flash wake timer, brownout warning, debug lock, vector map.
 Assumes asynchronous sources come straight from pins or analog blocks,
 and that boot code, watchdog and interrupt logic run on mclk.
*/
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module pmrs_sequencer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // asynchronous sources
    input wire logic reset_pin_n,
    input wire logic por_active,
    input wire logic bod_reset,
    input wire logic bod_warn,
    input wire logic osc_running,
    input wire logic pll_lock,
    input wire logic wake_irq,
    // same-domain sources
    input wire logic wdt_reset,
    input wire logic irq_pending,
    input wire logic flash_init_done,
    input wire logic boot_check_valid,
    input wire logic boot_checksum_ok,
    input wire logic [31:0] boot_sig_word,
    input wire logic chip_erase_done,
    // power and clock controls
    output logic sys_reset_n,
    output logic cpu_run,
    output logic periph_clk_run,
    output logic irc_out_en,
    output logic irc_power,
    output logic flash_power,
    output logic flash_access_ok,
    output logic rtc_osc_run,
    // synthesizer and dividers
    output logic pll_enable,
    output logic pll_connect,
    output logic [7:0] pll_pre_div,
    output logic [14:0] pll_mult,
    output logic [1:0] clk_src,
    output logic [7:0] cpu_clk_div,
    output logic [3:0] usb_clk_div,
    // misc system control
    output logic [31:0] periph_clk_en,
    output logic [1:0] vec_map,
    output logic debug_enable,
    output logic bod_irq
);
    pmrs_pkg::pmrs_state_e state;
    logic [6:0] a_s1;
    logic [6:0] a_s2;
    logic pin_n_s, por_s, bod_rst_s, bod_warn_s, osc_s, lock_s, wake_s;
    logic src_any;
    logic [7:0] rst_cnt;
    logic [12:0] wake_cnt;
    logic [11:0] fl_cnt;
    logic pll_conn_req;
    logic was_rc;
    logic bod_flag;
    logic debug_locked;
    logic pwr_cmd;
    logic wr_hit_bod;
    logic low_power;

    // pins pass two flops; only the second stage is read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            a_s1 <= 7'h01;
            a_s2 <= 7'h01;
        end else begin
            a_s1 <= {wake_irq, pll_lock, osc_running, bod_warn, bod_reset, por_active, reset_pin_n};
            a_s2 <= a_s1;
        end
    end
    assign {wake_s, lock_s, osc_s, bod_warn_s, bod_rst_s, por_s, pin_n_s} = a_s2;

    // brownout reset simply persists while its detector holds it
    assign src_any = !pin_n_s | por_s | bod_rst_s | wdt_reset;

    // reset release waits on all conditions; counter restarts on any source
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rst_cnt <= 8'h00;
            sys_reset_n <= 1'b0;
        end else if (src_any) begin
            rst_cnt <= 8'h00;
            sys_reset_n <= 1'b0;
        end else if (!sys_reset_n) begin
            if (osc_s && rst_cnt != pmrs_pkg::RST_CLKS) begin
                rst_cnt <= rst_cnt + 8'h01;
            end
            if (osc_s && rst_cnt == pmrs_pkg::RST_CLKS && flash_init_done) begin
                sys_reset_n <= 1'b1;
            end
        end
    end

    assign pwr_cmd = reg_wr && reg_addr == pmrs_pkg::OFS_PWR_MODE && state == pmrs_pkg::ST_RUN;
    assign low_power = state == pmrs_pkg::ST_SLEEP || state == pmrs_pkg::ST_PDOWN;

    // power mode state machine
    always_ff @(posedge mclk) begin
        if (!rst_n || !sys_reset_n) begin
            state <= pmrs_pkg::ST_RESET;
            wake_cnt <= 13'h0000;
            was_rc <= 1'b1;
        end else begin
            case (state)
                pmrs_pkg::ST_RESET: begin
                    state <= pmrs_pkg::ST_RUN;
                end
                pmrs_pkg::ST_RUN: begin
                    if (pwr_cmd) begin
                        was_rc <= clk_src == pmrs_pkg::SRC_RC;
                        case (reg_wdata[1:0])
                            pmrs_pkg::CMD_IDLE: state <= pmrs_pkg::ST_IDLE;
                            pmrs_pkg::CMD_SLEEP: state <= pmrs_pkg::ST_SLEEP;
                            pmrs_pkg::CMD_PDOWN: state <= pmrs_pkg::ST_PDOWN;
                            default: state <= pmrs_pkg::ST_RUN;
                        endcase
                    end
                end
                pmrs_pkg::ST_IDLE: begin
                    if (irq_pending || wake_s) begin
                        state <= pmrs_pkg::ST_RUN;
                    end
                end
                pmrs_pkg::ST_SLEEP: begin
                    // only clockless wake sources can end sleep
                    if (wake_s) begin
                        state <= pmrs_pkg::ST_WAKE_RES;
                        wake_cnt <= was_rc ? 13'(pmrs_pkg::RC_WAKE_CYC - 12'h001)
                                           : pmrs_pkg::XTAL_WAKE_CYC - 13'h0001;
                    end
                end
                pmrs_pkg::ST_PDOWN: begin
                    if (wake_s) begin
                        state <= pmrs_pkg::ST_WAKE_OSC;
                        wake_cnt <= 13'(pmrs_pkg::RC_START_CYC - 12'h001);
                    end
                end
                pmrs_pkg::ST_WAKE_OSC: begin
                    if (wake_cnt == 13'h0000) begin
                        state <= pmrs_pkg::ST_WAKE_RES;
                        wake_cnt <= 13'(pmrs_pkg::RC_WAKE_CYC - 12'h001);
                    end else begin
                        wake_cnt <= wake_cnt - 13'h0001;
                    end
                end
                pmrs_pkg::ST_WAKE_RES: begin
                    if (wake_cnt == 13'h0000) begin
                        state <= pmrs_pkg::ST_RUN;
                    end else begin
                        wake_cnt <= wake_cnt - 13'h0001;
                    end
                end
                default: state <= pmrs_pkg::ST_RESET;
            endcase
        end
    end

    // flash timer reloads throughout power-down, counts after wake
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fl_cnt <= 12'h000;
        end else if (state == pmrs_pkg::ST_PDOWN) begin
            fl_cnt <= pmrs_pkg::FLASH_CYC;
        end else if (fl_cnt != 12'h000) begin
            fl_cnt <= fl_cnt - 12'h001;
        end
    end

    assign cpu_run = state == pmrs_pkg::ST_RUN;
    assign periph_clk_run = state == pmrs_pkg::ST_RUN || state == pmrs_pkg::ST_IDLE
                            || state == pmrs_pkg::ST_WAKE_RES;
    assign irc_out_en = !low_power && state != pmrs_pkg::ST_WAKE_OSC;
    assign irc_power = state != pmrs_pkg::ST_PDOWN;
    assign flash_power = state != pmrs_pkg::ST_PDOWN;
    assign flash_access_ok = flash_power && fl_cnt == 12'h000 && sys_reset_n;
    assign rtc_osc_run = 1'b1;
    // connect only takes effect once the lock is seen
    assign pll_connect = pll_enable && pll_conn_req && lock_s;

    // synthesizer control; hardware only ever turns it off
    always_ff @(posedge mclk) begin
        if (!rst_n || !sys_reset_n || low_power) begin
            pll_enable <= 1'b0;
            pll_conn_req <= 1'b0;
        end else if (reg_wr && reg_addr == pmrs_pkg::OFS_PLL_CTRL) begin
            pll_enable <= reg_wdata[pmrs_pkg::PLL_EN_BIT];
            pll_conn_req <= reg_wdata[pmrs_pkg::PLL_CONN_BIT];
        end
    end

    // stored as value minus one, giving 1..256 and 1..32768
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pll_pre_div <= pmrs_pkg::PLL_N_RST;
            pll_mult <= pmrs_pkg::PLL_M_RST;
        end else if (reg_wr && reg_addr == pmrs_pkg::OFS_PLL_CFG) begin
            pll_pre_div <= reg_wdata[pmrs_pkg::PLL_N_LSB +: 8];
            pll_mult <= reg_wdata[pmrs_pkg::PLL_M_LSB +: 15];
        end
    end

    // dividers cleared in sleep and power-down; source forced to RC in power-down only
    always_ff @(posedge mclk) begin
        if (!rst_n || !sys_reset_n) begin
            clk_src <= pmrs_pkg::SRC_RC;
            cpu_clk_div <= 8'h00;
            usb_clk_div <= 4'h0;
        end else if (low_power) begin
            cpu_clk_div <= 8'h00;
            usb_clk_div <= 4'h0;
            if (state == pmrs_pkg::ST_PDOWN) begin
                clk_src <= pmrs_pkg::SRC_RC;
            end
        end else if (reg_wr) begin
            if (reg_addr == pmrs_pkg::OFS_CLK_SRC) begin
                clk_src <= reg_wdata[1:0];
            end
            if (reg_addr == pmrs_pkg::OFS_CPU_DIV) begin
                cpu_clk_div <= reg_wdata[7:0];
            end
            if (reg_addr == pmrs_pkg::OFS_USB_DIV) begin
                usb_clk_div <= reg_wdata[3:0];
            end
        end
    end

    // gating and vector map return to defaults on any chip reset
    always_ff @(posedge mclk) begin
        if (!rst_n || !sys_reset_n) begin
            periph_clk_en <= pmrs_pkg::PCLK_EN_RST;
            vec_map <= pmrs_pkg::MAP_BOOT;
        end else if (reg_wr) begin
            if (reg_addr == pmrs_pkg::OFS_PCLK_EN) begin
                periph_clk_en <= reg_wdata;
            end
            if (reg_addr == pmrs_pkg::OFS_MEM_MAP && reg_wdata[1:0] != 2'h3) begin
                vec_map <= reg_wdata[1:0];
            end
        end
    end

    // sticky warning, write one clears; a new warning beats the clear
    assign wr_hit_bod = reg_wr && reg_addr == pmrs_pkg::OFS_BOD_STAT && reg_wdata[0];
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bod_flag <= 1'b0;
        end else if (bod_warn_s) begin
            bod_flag <= 1'b1;
        end else if (wr_hit_bod) begin
            bod_flag <= 1'b0;
        end
    end
    assign bod_irq = bod_flag;

    // lock survives chip resets; only an erase or rst_n unlocks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            debug_locked <= 1'b0;
        end else if (boot_check_valid && boot_checksum_ok
                     && boot_sig_word == pmrs_pkg::DEBUG_SIG) begin
            debug_locked <= 1'b1;
        end else if (chip_erase_done) begin
            debug_locked <= 1'b0;
        end
    end
    assign debug_enable = !debug_locked;

    // read data in the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                pmrs_pkg::OFS_PLL_CTRL: reg_rdata <= {29'h0000_0000, lock_s, pll_conn_req,
                                                      pll_enable};
                pmrs_pkg::OFS_PLL_CFG: reg_rdata <= {9'h000, pll_mult, pll_pre_div};
                pmrs_pkg::OFS_CLK_SRC: reg_rdata <= {30'h0000_0000, clk_src};
                pmrs_pkg::OFS_CPU_DIV: reg_rdata <= {24'h00_0000, cpu_clk_div};
                pmrs_pkg::OFS_USB_DIV: reg_rdata <= {28'h000_0000, usb_clk_div};
                pmrs_pkg::OFS_STATUS: reg_rdata <= {26'h000_0000, debug_locked,
                                                    flash_access_ok, pll_connect, state};
                pmrs_pkg::OFS_PCLK_EN: reg_rdata <= periph_clk_en;
                pmrs_pkg::OFS_MEM_MAP: reg_rdata <= {30'h0000_0000, vec_map};
                pmrs_pkg::OFS_BOD_STAT: reg_rdata <= {30'h0000_0000, bod_warn_s, bod_flag};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence sleep_wake_rc;
        state == pmrs_pkg::ST_SLEEP && wake_s && was_rc && sys_reset_n && !src_any;
    endsequence
    sequence wake_res_4;
        (state == pmrs_pkg::ST_WAKE_RES && !cpu_run) [*4] ##1 cpu_run;
    endsequence

    AST_SRC_RESET: assert property (src_any |=> !sys_reset_n)
        else $error("reset source did not hold internal reset");
    AST_RELEASE_COND: assert property ($rose(sys_reset_n) |->
        $past(flash_init_done) && $past(osc_s) && $past(rst_cnt) == pmrs_pkg::RST_CLKS)
        else $error("reset released before its conditions");
    AST_RESET_PLL_OFF: assert property (!sys_reset_n |=> !pll_enable && clk_src == pmrs_pkg::SRC_RC)
        else $error("synthesizer alive or source not RC in reset");
    AST_SLEEP_CLEARS: assert property ($rose(low_power) |=>
        !pll_enable && cpu_clk_div == 8'h00 && usb_clk_div == 4'h0)
        else $error("sleep entry did not clear synthesizer and dividers");
    AST_SLEEP_WAKE_RC: assert property (sleep_wake_rc |=> wake_res_4 or !sys_reset_n)
        else $error("RC sleep wake not four cycles");
    AST_PDOWN_WAKE: assert property (state == pmrs_pkg::ST_PDOWN && wake_s && sys_reset_n
        |=> (state == pmrs_pkg::ST_WAKE_OSC && !irc_out_en) [*8])
        else $error("power-down wake skipped RC start-up");
    AST_PDOWN_OFF: assert property (state == pmrs_pkg::ST_PDOWN |-> !irc_power && !flash_power)
        else $error("RC or flash powered in power-down");
    AST_FLASH_BLOCK: assert property ($fell(state == pmrs_pkg::ST_PDOWN) |->
        !flash_access_ok [*8])
        else $error("flash opened too soon after power-down");
    AST_IDLE: assert property (state == pmrs_pkg::ST_IDLE |-> !cpu_run && periph_clk_run)
        else $error("idle clock gating wrong");
    AST_BOD_FLAG: assert property (bod_warn_s |=> bod_flag && bod_irq)
        else $error("brownout warning lost");
    AST_DEBUG_LOCK: assert property (boot_check_valid && boot_checksum_ok
        && boot_sig_word == pmrs_pkg::DEBUG_SIG |=> !debug_enable)
        else $error("debug not locked by signature");
endmodule

/* verif/tb_pmrs_sequencer.sv */
/*
 Self-checking bench for pmrs_sequencer: register port, power modes, wake timing,
 reset sources, brownout flag, debug lock and vector map.
 Assumes pmrs_pkg and the design are compiled first; the bench drives all ports itself.
*/
`timescale 1ns/10ps
module tb_pmrs_sequencer;
    logic mclk, rst_n, reg_wr, reg_rd, reset_pin_n, por_active, bod_reset, bod_warn;
    logic osc_running, pll_lock, wake_irq, wdt_reset, irq_pending, flash_init_done;
    logic boot_check_valid, boot_checksum_ok, chip_erase_done;
    logic [7:0] reg_addr, pll_pre_div, cpu_clk_div;
    logic [31:0] reg_wdata, reg_rdata, boot_sig_word, periph_clk_en;
    logic sys_reset_n, cpu_run, periph_clk_run, irc_out_en, irc_power, flash_power;
    logic flash_access_ok, rtc_osc_run, pll_enable, pll_connect, debug_enable, bod_irq;
    logic [14:0] pll_mult;
    logic [1:0] clk_src, vec_map;
    logic [3:0] usb_clk_div;
    int fail_count, num_checks, n, m_n, m_m, m_pcl;
    int nv[3];
    int mv[3];

    pmrs_sequencer u_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reset_pin_n, .por_active, .bod_reset, .bod_warn, .osc_running, .pll_lock, .wake_irq,
        .wdt_reset, .irq_pending, .flash_init_done, .boot_check_valid, .boot_checksum_ok,
        .boot_sig_word, .chip_erase_done, .sys_reset_n, .cpu_run, .periph_clk_run,
        .irc_out_en, .irc_power, .flash_power, .flash_access_ok, .rtc_osc_run, .pll_enable,
        .pll_connect, .pll_pre_div, .pll_mult, .clk_src, .cpu_clk_div, .usb_clk_div,
        .periph_clk_en, .vec_map, .debug_enable, .bod_irq);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
        num_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("ERROR %0t %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return sys_reset_n === 1'b1;
            1: return cpu_run === 1'b1;
            default: return flash_access_ok === 1'b1;
        endcase
    endfunction

    // every wait is bounded; running out counts as a mismatch and ends the run
    task automatic wait_on(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (!pick(sel)) begin
            if (cnt >= lim) begin
                fail_count++;
                $display("ERROR %0t wait %0d timed out", $time, sel);
                complete_run();
            end
            cyc(1);
            cnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data is only valid in the single cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    // wake_irq is a level; counted from its rise to the cpu clock coming back
    task automatic wake_cnt(input int lo, input int hi);
        @(posedge mclk);
        wake_irq <= 1'b1;
        #1;
        wait_on(1, hi + 5, n);
        chk_cnt(n, lo, hi, "wake");
        @(posedge mclk);
        wake_irq <= 1'b0;
        #1;
    endtask

    task automatic boot(input logic [31:0] sig, input logic ok);
        @(posedge mclk);
        boot_sig_word <= sig;
        boot_checksum_ok <= ok;
        boot_check_valid <= 1'b1;
        @(posedge mclk);
        boot_check_valid <= 1'b0;
        cyc(2);
    endtask

    initial begin
        n = $urandom(32'h281f);
        {rst_n, reg_wr, reg_rd, por_active, bod_reset, bod_warn, pll_lock} = '0;
        {wake_irq, wdt_reset, irq_pending, flash_init_done, boot_check_valid} = '0;
        {boot_checksum_ok, chip_erase_done} = '0;
        reset_pin_n = 1'b1;
        osc_running = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        boot_sig_word = 32'h0000_0000;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        cyc(30);
        chk(sys_reset_n, 0, "release before flash ready");
        @(posedge mclk);
        flash_init_done <= 1'b1;
        wait_on(0, 40, n);
        chk(periph_clk_en, pmrs_pkg::PCLK_EN_RST, "pclk reset");
        chk(vec_map, pmrs_pkg::MAP_BOOT, "vector map reset");
        chk(clk_src, pmrs_pkg::SRC_RC, "clock source reset");
        chk(pll_enable, 0, "synth off");
        wait_on(1, 5, n);
        // divider boundaries and one random pair; model keeps value minus one
        nv = '{0, 255, $urandom_range(255, 0)};
        mv = '{0, 32767, $urandom_range(32767, 0)};
        for (int i = 0; i < 3; i++) begin
            m_n = nv[i];
            m_m = mv[i];
            wr(pmrs_pkg::OFS_PLL_CFG, 32'((m_m << 8) | m_n));
            cyc(1);
            chk(pll_pre_div, 32'(m_n), "pre divider");
            chk(pll_mult, 32'(m_m), "multiplier");
            rdc(pmrs_pkg::OFS_PLL_CFG, 32'((m_m << 8) | m_n), "cfg readback");
        end
        m_pcl = $urandom;
        wr(pmrs_pkg::OFS_PCLK_EN, 32'(m_pcl));
        cyc(1);
        chk(periph_clk_en, 32'(m_pcl), "pclk gates");
        rdc(pmrs_pkg::OFS_PCLK_EN, 32'(m_pcl), "pclk readback");
        for (int i = 0; i < 4; i++) begin
            wr(pmrs_pkg::OFS_MEM_MAP, 32'(i));
            cyc(1);
            chk(vec_map, (i == 3) ? 32'h2 : 32'(i), "vector map");
        end
        rdc(8'h3C, 32'h0000_0000, "unmapped read");
        wr(pmrs_pkg::OFS_PLL_CTRL, 32'h0000_0003);
        cyc(4);
        chk(pll_connect, 0, "connect before lock");
        @(posedge mclk);
        pll_lock <= 1'b1;
        cyc(4);
        chk(pll_connect, 1, "connect after lock");
        rdc(pmrs_pkg::OFS_PLL_CTRL, 32'h0000_0007, "ctrl readback");
        // idle: cpu stops, peripherals run, any interrupt resumes
        wr(pmrs_pkg::OFS_PWR_MODE, 32'(pmrs_pkg::CMD_IDLE));
        cyc(2);
        chk({cpu_run, periph_clk_run, irc_out_en}, 32'h3, "idle clocks");
        @(posedge mclk);
        irq_pending <= 1'b1;
        #1;
        wait_on(1, 5, n);
        @(posedge mclk);
        irq_pending <= 1'b0;
        // sleep from the RC source
        wr(pmrs_pkg::OFS_CPU_DIV, 32'($urandom_range(255, 1)));
        wr(pmrs_pkg::OFS_USB_DIV, 32'h0000_0009);
        wr(pmrs_pkg::OFS_PWR_MODE, 32'(pmrs_pkg::CMD_SLEEP));
        cyc(3);
        chk({pll_enable, pll_connect, cpu_clk_div, usb_clk_div}, 0, "sleep clears");
        chk({cpu_run, periph_clk_run, irc_out_en}, 0, "sleep gates");
        chk({irc_power, flash_power, rtc_osc_run}, 32'h7, "sleep powered");
        @(posedge mclk);
        irq_pending <= 1'b1;
        @(posedge mclk);
        irq_pending <= 1'b0;
        cyc(10);
        chk(cpu_run, 0, "clocked irq ignored in sleep");
        wake_cnt(6, 8);
        rdc(pmrs_pkg::OFS_STATUS, 32'h0000_0011, "status after wake");
        // sleep from the crystal source
        wr(pmrs_pkg::OFS_CLK_SRC, 32'(pmrs_pkg::SRC_MAIN));
        wr(pmrs_pkg::OFS_PWR_MODE, 32'(pmrs_pkg::CMD_SLEEP));
        cyc(3);
        wake_cnt(4098, 4101);
        // power-down with the synthesizer on
        wr(pmrs_pkg::OFS_PLL_CTRL, 32'h0000_0001);
        wr(pmrs_pkg::OFS_PWR_MODE, 32'(pmrs_pkg::CMD_PDOWN));
        cyc(3);
        chk({irc_power, flash_power, flash_access_ok}, 0, "pdown power");
        chk({pll_enable, clk_src}, 32'(pmrs_pkg::SRC_RC), "pdown bypass");
        wake_cnt(605, 609);
        chk(flash_access_ok, 0, "flash blocked");
        chk(clk_src, pmrs_pkg::SRC_RC, "rc after pdown");
        wait_on(2, 500, n);
        chk_cnt(n, 392, 400, "flash timer");
        // two-stage brownout: warning flag first
        @(posedge mclk);
        bod_warn <= 1'b1;
        cyc(4);
        chk(bod_irq, 1, "brownout flag");
        rdc(pmrs_pkg::OFS_BOD_STAT, 32'h0000_0003, "brownout status");
        @(posedge mclk);
        bod_warn <= 1'b0;
        cyc(4);
        wr(pmrs_pkg::OFS_BOD_STAT, 32'h0000_0001);
        cyc(1);
        chk(bod_irq, 0, "brownout clear");
        boot(pmrs_pkg::DEBUG_SIG, 1'b0);
        chk(debug_enable, 1, "bad checksum");
        boot(pmrs_pkg::DEBUG_SIG ^ 32'h0000_0001, 1'b1);
        chk(debug_enable, 1, "wrong signature");
        boot(pmrs_pkg::DEBUG_SIG, 1'b1);
        chk(debug_enable, 0, "debug locked");
        @(posedge mclk);
        chip_erase_done <= 1'b1;
        @(posedge mclk);
        chip_erase_done <= 1'b0;
        cyc(2);
        chk(debug_enable, 1, "erase unlocks");
        // each of the four sources alone; oscillator kept down on the first
        for (int s = 0; s < 4; s++) begin
            wr(pmrs_pkg::OFS_MEM_MAP, 32'(pmrs_pkg::MAP_SRAM));
            wr(pmrs_pkg::OFS_CLK_SRC, 32'(pmrs_pkg::SRC_MAIN));
            @(posedge mclk);
            reset_pin_n <= (s != 0);
            wdt_reset <= (s == 1);
            por_active <= (s == 2);
            bod_reset <= (s == 3);
            osc_running <= (s != 0);
            cyc(5);
            chk({sys_reset_n, cpu_run}, 0, "reset source");
            @(posedge mclk);
            {wdt_reset, por_active, bod_reset} <= 3'b000;
            reset_pin_n <= 1'b1;
            if (s == 0) begin
                cyc(30);
                chk(sys_reset_n, 0, "held without oscillator");
                @(posedge mclk);
                osc_running <= 1'b1;
            end
            #1;
            wait_on(0, 40, n);
            chk_cnt(n, 17, 24, "reset release");
            chk({vec_map, clk_src, pll_enable}, 0, "post reset state");
            wait_on(1, 5, n);
        end
        complete_run();
    end
endmodule
